// ===== hdl/icbe_pkg.sv
// package for the inc/dec/complement/branch execute block
// assumes a 12-bit instruction word and an 8-bit data path
package icbe_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned INSTR_W = 12;
    localparam int unsigned FADDR_W = 5;
    localparam int unsigned PC_W = 11;

    // opcode fields, instruction bits 11:6 or 11:9
    localparam logic [5:0] OPC_COMP = 6'h09;
    localparam logic [5:0] OPC_DEC = 6'h03;
    localparam logic [5:0] OPC_DSZ = 6'h0b;
    localparam logic [5:0] OPC_INC = 6'h0a;
    localparam logic [2:0] OPC_JUMP = 3'h5;

    // field positions
    localparam int unsigned DEST_BIT = 5;
    localparam int unsigned FADDR_LSB = 0;
    localparam int unsigned JUMP_LSB = 0;
    localparam int unsigned JUMP_W = 9;
    localparam int unsigned PAGE_LSB = 5;
    localparam int unsigned PAGE_W = 2;

    // reset values, plus the unit step ONE
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [DATA_W-1:0] ONE = 8'h01;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_COMP = 3'h1,
        OP_DEC = 3'h2,
        OP_DSZ = 3'h3,
        OP_INC = 3'h4,
        OP_JUMP = 3'h5
    } icbe_op_e;

    // gray coded: exec <-> flush differ in one bit
    typedef enum logic {
        ST_EXEC = 1'b0,
        ST_FLUSH = 1'b1
    } icbe_state_e;

    function automatic icbe_op_e icbe_decode(input logic [INSTR_W-1:0] ins);
        icbe_op_e op;
        op = OP_NONE;
        if (ins[11:9] == OPC_JUMP)
            op = OP_JUMP;
        else if (ins[11:6] == OPC_COMP)
            op = OP_COMP;
        else if (ins[11:6] == OPC_DEC)
            op = OP_DEC;
        else if (ins[11:6] == OPC_DSZ)
            op = OP_DSZ;
        else if (ins[11:6] == OPC_INC)
            op = OP_INC;
        return op;
    endfunction : icbe_decode

endpackage : icbe_pkg

// ===== hdl/icbe_alu_if.sv
// carrier between the execute core and its arithmetic unit
// assumes both ends share one clock; purely combinational traffic
`timescale 1ns/1ps
`default_nettype none
interface icbe_alu_if;
    import icbe_pkg::*;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic zero;
    modport core (output instr, output operand, input result, input zero);
    modport alu (input instr, input operand, output result, output zero);
endinterface : icbe_alu_if
`default_nettype wire

// ===== hdl/icbe_alu.sv
// arithmetic unit: complement, decrement, increment of one operand
// assumes the core presents the executing instruction and its operand
`timescale 1ns/1ps
`default_nettype none
module icbe_alu
    import icbe_pkg::*;
(
    icbe_alu_if.alu bus // instruction, operand and result
);

    always_comb
    begin
        unique case (icbe_decode(bus.instr))
            OP_COMP: bus.result = ~bus.operand;
            // 8-bit target drops the carry, so both wrap mod 256
            OP_DEC, OP_DSZ:
                bus.result = bus.operand - ONE;
            OP_INC: bus.result = bus.operand + ONE;
            default: bus.result = bus.operand;
        endcase
    end

    assign bus.zero = (bus.result == 8'h00);

endmodule : icbe_alu
`default_nettype wire

// ===== hdl/icbe_exec.sv
// execute stage for complement, decrement, decrement-skip, increment
// and the unconditional jump of a small 12-bit-word core.
// assumes one instruction per i_clk, file register read combinational
// on o_file_addr, and the page bits supplied by the status register.
//
// Behaviour
// - complement writes inverted register, updates zero
// - dest bit 0 to W, 1 to file
// - decrement writes register minus one, updates zero
// - decrement-skip writes minus one, flags untouched
// - decrement-skip zero result flushes next instruction
// - jump loads 9-bit immediate into pc low
// - jump copies page bits into pc 10:9
// - jump takes two cycles, fetched word flushed
// - increment writes register plus one, updates zero
`timescale 1ns/1ps
`default_nettype none
module icbe_exec
    import icbe_pkg::*;
(
    input wire logic i_clk, // core instruction clock
    input wire logic i_rst, // synchronous reset, active high
    input wire logic [INSTR_W-1:0] i_instr, // instruction now executing
    input wire logic [PAGE_W-1:0] i_page, // status bits 6:5
    input wire logic [DATA_W-1:0] i_file_data, // data at o_file_addr
    output logic [FADDR_W-1:0] o_file_addr, // file read address
    output logic o_file_we, // file write strobe
    output logic [FADDR_W-1:0] o_file_waddr, // file write address
    output logic [DATA_W-1:0] o_file_wdata, // file write data
    output logic [DATA_W-1:0] o_w, // working register
    output logic o_zero, // zero flag
    output logic [PC_W-1:0] o_pc, // fetch address
    output logic o_flush // current word discarded
);

    icbe_alu_if alu_bus ();
    icbe_alu u_alu (.bus(alu_bus));

    icbe_state_e state_r;
    logic [PC_W-1:0] pc_r;
    logic [DATA_W-1:0] w_r;
    logic zero_r;
    logic file_we_r;
    logic [FADDR_W-1:0] file_waddr_r;
    logic [DATA_W-1:0] file_wdata_r;

    icbe_op_e op;
    logic live;
    logic dest_file;
    logic reg_op;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] operand;
    logic skip;

    assign op = icbe_decode(i_instr);
    assign live = (state_r == ST_EXEC);
    assign dest_file = i_instr[DEST_BIT];
    assign faddr = i_instr[FADDR_LSB +: FADDR_W];
    assign reg_op = live && (op inside {OP_COMP, OP_DEC, OP_DSZ, OP_INC});

    // the file is written one edge late; forward the pending value so a
    // back-to-back read of the same register never sees stale data
    assign operand = (file_we_r && file_waddr_r == faddr) ?
        file_wdata_r : i_file_data;

    assign alu_bus.instr = i_instr;
    assign alu_bus.operand = operand;

    assign skip = live && op == OP_DSZ && alu_bus.zero;

    // sequencing: flush the prefetched word after a jump or a skip
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            state_r <= ST_EXEC;
        else
        begin
            unique case (state_r)
                ST_EXEC:
                    if (skip || (live && op == OP_JUMP))
                        state_r <= ST_FLUSH;
                ST_FLUSH:
                    state_r <= ST_EXEC;
            endcase
        end
    end

    // program counter
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            pc_r <= PC_RESET;
        else if (live && op == OP_JUMP)
            pc_r <= {i_page, i_instr[JUMP_LSB +: JUMP_W]};
        else
            pc_r <= pc_r + 11'h001;
    end

    // working register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            w_r <= W_RESET;
        else if (reg_op && !dest_file)
            w_r <= alu_bus.result;
    end

    // file write-back
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            file_we_r <= 1'b0;
            file_waddr_r <= 5'h00;
            file_wdata_r <= 8'h00;
        end
        else
        begin
            file_we_r <= reg_op && dest_file;
            file_waddr_r <= faddr;
            file_wdata_r <= alu_bus.result;
        end
    end

    // zero flag; the skip variant leaves status alone
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            zero_r <= ZERO_RESET;
        else if (reg_op && op != OP_DSZ)
            zero_r <= alu_bus.zero;
    end

    assign o_file_addr = faddr;
    assign o_file_we = file_we_r;
    assign o_file_waddr = file_waddr_r;
    assign o_file_wdata = file_wdata_r;
    assign o_w = w_r;
    assign o_zero = zero_r;
    assign o_pc = pc_r;
    assign o_flush = !live;

    comp_result_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_COMP && !dest_file
        |=> o_w == ~$past(operand) && o_zero == (o_w == 8'h00))
        else $error("complement result wrong");

    dest_route_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        reg_op && dest_file
        |=> o_file_we && o_file_waddr == $past(faddr) && $stable(o_w))
        else $error("file destination not honoured");

    dec_result_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_DEC && dest_file
        |=> o_file_wdata == 8'($past(operand) - 8'h01))
        else $error("decrement result wrong");

    dsz_flags_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_DSZ |=> $stable(o_zero))
        else $error("skip decrement touched zero flag");

    dsz_skip_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_DSZ && operand == 8'h01
        |=> o_flush ##1 !o_flush)
        else $error("skip did not flush exactly one word");

    jump_target_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_JUMP
        |=> o_pc[8:0] == $past(i_instr[8:0]))
        else $error("jump low bits wrong");

    jump_page_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_JUMP |=> o_pc[10:9] == $past(i_page))
        else $error("jump page bits wrong");

    jump_two_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_JUMP
        |=> o_flush && $stable(o_zero) ##1 !o_flush)
        else $error("jump not two cycles");

    inc_result_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_INC && !dest_file
        |=> o_w == 8'($past(operand) + 8'h01))
        else $error("increment result wrong");

    single_cycle_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op inside {OP_COMP, OP_DEC, OP_INC} |=> !o_flush)
        else $error("register op stalled");

    zero_flag_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        reg_op && op != OP_DSZ |=> o_zero == $past(alu_bus.result == 8'h00))
        else $error("zero flag wrong");

    wrap_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_INC && dest_file && operand == 8'hff
        |=> o_file_wdata == 8'h00 && o_zero)
        else $error("increment did not wrap");

    dsz_result_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_DSZ && !dest_file
        |=> o_w == 8'($past(operand) - 8'h01) && !o_file_we)
        else $error("skip decrement result wrong");

    dsz_noskip_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        live && op == OP_DSZ && operand != 8'h01 |=> !o_flush)
        else $error("skip decrement flushed on nonzero result");

    flush_nop_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_flush |=> !o_file_we && $stable(o_w) && $stable(o_zero))
        else $error("discarded word changed state");

    pc_step_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !(live && op == OP_JUMP) |=> o_pc == 11'($past(o_pc) + 11'h001))
        else $error("pc did not advance by one");

endmodule : icbe_exec
`default_nettype wire

// ===== tb/incdec_complement_branch_exec_bench.sv
// self-checking bench for the inc/dec/complement/jump execute block
// assumes icbe_pkg and icbe_exec compiled first; bench plays file memory
`timescale 1ns/1ps
`default_nettype none
module incdec_complement_branch_exec_bench;
    import icbe_pkg::*;

    logic i_clk;
    logic i_rst;
    logic [INSTR_W-1:0] i_instr;
    logic [PAGE_W-1:0] i_page;
    logic [DATA_W-1:0] i_file_data;
    logic [FADDR_W-1:0] o_file_addr;
    logic o_file_we;
    logic [FADDR_W-1:0] o_file_waddr;
    logic [DATA_W-1:0] o_file_wdata;
    logic [DATA_W-1:0] o_w;
    logic o_zero;
    logic [PC_W-1:0] o_pc;
    logic o_flush;
    int num_errors = 0;
    int checks_done = 0;
    logic [PC_W-1:0] pc_exp;

    icbe_exec dut_u (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_instr(i_instr),
        .i_page(i_page),
        .i_file_data(i_file_data),
        .o_file_addr(o_file_addr),
        .o_file_we(o_file_we),
        .o_file_waddr(o_file_waddr),
        .o_file_wdata(o_file_wdata),
        .o_w(o_w),
        .o_zero(o_zero),
        .o_pc(o_pc),
        .o_flush(o_flush)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // entered just after an edge; returns 1 ns after the executing edge
    task automatic step(input logic [INSTR_W-1:0] ins,
                        input logic [DATA_W-1:0] fd);
        i_instr = ins;
        i_file_data = fd;
        @(posedge i_clk);
        #1;
        pc_exp = pc_exp + 11'h001;
    endtask : step

    task automatic reg_op(input logic [5:0] opc, input logic d,
                          input logic [4:0] f, input logic [7:0] x,
                          input logic [7:0] res);
        logic [DATA_W-1:0] w_old;
        w_old = o_w;
        step({opc, d, f}, x);
        check(o_file_addr, f);
        check(o_pc, pc_exp);
        check(o_flush, 1'b0);
        check(o_zero, res == 8'h00);
        check(o_file_we, d);
        if (d)
        begin
            check(o_file_waddr, f);
            check(o_file_wdata, res);
            check(o_w, w_old);
        end
        else
            check(o_w, res);
    endtask : reg_op

    // distinct consecutive addresses keep forwarding out of the way
    task automatic test_reg_ops;
        logic [7:0] vals [5];
        int j;
        vals = '{8'h13, 8'h00, 8'hff, 8'h01, 8'h80};
        j = 0;
        for (int d = 0; d < 2; d++)
            for (int i = 0; i < 5; i++)
            begin
                reg_op(OPC_COMP, d[0], 5'(j), vals[i],
                       ~vals[i]);
                reg_op(OPC_DEC, d[0], 5'(j + 1), vals[i],
                       vals[i] - 8'h01);
                reg_op(OPC_INC, d[0], 5'(j + 2), vals[i],
                       vals[i] + 8'h01);
                j = j + 3;
            end
        // same register back to back: bench serves a stale value
        reg_op(OPC_INC, 1'b1, 5'h1e, 8'h7f, 8'h80);
        reg_op(OPC_DEC, 1'b0, 5'h1e, 8'h00, 8'h7f);
    endtask : test_reg_ops

    task automatic test_skip;
        for (int z = 0; z < 2; z++)
        begin
            reg_op(OPC_INC, 1'b0, 5'h01, z ? 8'hff : 8'h00,
                   z ? 8'h00 : 8'h01);
            step({OPC_DSZ, 1'b0, 5'h02}, 8'h02);
            check(o_w, 8'h01);
            check(o_zero, z[0]);
            check(o_flush, 1'b0);
            step({OPC_DSZ, 1'b1, 5'h03}, 8'h01);
            check(o_file_we, 1'b1);
            check(o_file_wdata, 8'h00);
            check(o_zero, z[0]);
            check(o_flush, 1'b1);
            step({OPC_INC, 1'b0, 5'h04}, 8'h05);
            check(o_w, 8'h01);
            check(o_file_we, 1'b0);
            check(o_flush, 1'b0);
            check(o_pc, pc_exp);
        end
    endtask : test_skip

    task automatic test_jump;
        logic [8:0] k;
        logic zero_old;
        for (int p = 0; p < 4; p++)
        begin
            k = 9'h1a5 ^ 9'(p * 9'h0c3);
            i_page = p[1:0];
            zero_old = o_zero;
            step({OPC_JUMP, k}, 8'h00);
            pc_exp = {p[1:0], k};
            check(o_pc, pc_exp);
            check(o_flush, 1'b1);
            check(o_zero, zero_old);
            step({OPC_INC, 1'b0, 5'h05}, 8'h40);
            check(o_flush, 1'b0);
            check(o_w, 8'h01);
            check(o_pc, pc_exp);
        end
    endtask : test_jump

    initial
    begin
        #20000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        i_rst = 1'b1;
        i_instr = 12'h000;
        i_page = 2'h0;
        i_file_data = 8'h00;
        pc_exp = PC_RESET;
        repeat (6) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        check(o_pc, PC_RESET);
        check(o_w, W_RESET);
        check(o_zero, ZERO_RESET);
        check(o_file_we, 1'b0);
        check(o_flush, 1'b0);
        test_reg_ops();
        test_skip();
        test_jump();
        report_and_stop();
    end

endmodule : incdec_complement_branch_exec_bench
`default_nettype wire
